//--- hdl/pti_pkg.sv
// Summary of operation
// RULE1 - Writing 1 to the soft reinit command restores defaults and reloads OTP settings.
// RULE2 - The soft reinit command bit clears itself once the reset action is taken.
// RULE3 - Load current result flag (bit 7) sets on a new measurement and holds until written 1.
// RULE4 - Monitor summary flag (bit 6) reads 1 while the monitor event register is non-zero.
// RULE5 - Boost summary flag (bit 5) reads 1 while the boost event register is non-zero.
// RULE6 - Step-down summary flag (bit 4) reads 1 while the step-down event register is non-zero.
// RULE7 - External clock change flag (bit 3) latches on any validity change, cleared by writing 1.
// RULE8 - Over-temperature shutdown latches flag bit 2 and disables enabled converters.
// RULE9 - While the shutdown flag is set no converter may be enabled.
// RULE10 - Clearing the shutdown flag re-enables converters and clears the thermal warning status; code clears the latched warning flag (bit 1) instead.
// RULE11 - Thermal warning flag (bit 1) latches on warning level, live level shown in status, W1C.
// RULE12 - Overvoltage flag (bit 0) latches on overvoltage, live level shown in status, W1C.
// RULE13 - Soft reinit or supply undervoltage latches a reset-occurred flag, cleared by writing 1.
// RULE14 - Writing 0 leaves latched flags alone and writes to summary flags are ignored.
package pti_pkg;
  localparam logic [7:0] REG_SOFT_RESET = 8'h1F;
  localparam logic [7:0] REG_TOP_FLAGS  = 8'h20;
  localparam logic [7:0] REG_TOP_FLAGS2 = 8'h21;
  localparam logic [7:0] REG_TOP_STATUS = 8'h2F;
  localparam logic [7:0] REG_ZERO       = 8'h00;
  localparam int BIT_CMD   = 0;
  localparam int BIT_ILOAD = 7;
  localparam int BIT_MON   = 6;
  localparam int BIT_BOOST = 5;
  localparam int BIT_BUCK  = 4;
  localparam int BIT_SYNC  = 3;
  localparam int BIT_TSD   = 2;
  localparam int BIT_TWARN = 1;
  localparam int BIT_OVERVOLT = 0;
  localparam int BIT_RSTOC = 0;
  localparam logic [7:0] LATCH_MASK = 8'h8F;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pti_wr_t;

  typedef struct packed {
    logic       ilad_done;
    logic       sync_valid;
    logic       tsd;
    logic       twarn;
    logic       overvolt;
    logic       uvlo;
  } pti_evt_t;
endpackage : pti_pkg

//--- hdl/pti_top.sv
`timescale 1ns/1ps
module pti_top (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire pti_pkg::pti_wr_t host_wr,
  input  wire logic [7:0]       rd_addr,
  input  wire pti_pkg::pti_evt_t evt_in,
  input  wire logic [7:0]       buck_event_reg,
  input  wire logic [7:0]       boost_event_reg,
  input  wire logic [7:0]       monitor_event_reg,
  input  wire logic [2:0]       conv_en_req,
  output logic [7:0]            rd_data,
  output logic [2:0]            conv_en,
  output logic                  defaults_restore,
  output logic                  otp_reload
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pti_pkg::pti_evt_t evt_m_q, evt_s_q, evt_p_q;
  logic [2:0]        en_m_q, en_s_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evt_m_q <= '0;
      evt_s_q <= '0;
      evt_p_q <= '0;
      en_m_q  <= '0;
      en_s_q  <= '0;
    end else begin
      evt_m_q <= evt_in;
      evt_s_q <= evt_m_q;
      evt_p_q <= evt_s_q;
      en_m_q  <= conv_en_req;
      en_s_q  <= en_m_q;
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic       wr_cmd, wr_top, wr_top2;
  logic [7:0] clr_top;
  logic       cmd_q;
  assign wr_cmd  = host_wr.wr && host_wr.addr == pti_pkg::REG_SOFT_RESET;
  assign wr_top  = host_wr.wr && host_wr.addr == pti_pkg::REG_TOP_FLAGS;
  assign wr_top2 = host_wr.wr && host_wr.addr == pti_pkg::REG_TOP_FLAGS2;
  assign clr_top = wr_top ? (host_wr.wdata & pti_pkg::LATCH_MASK) : pti_pkg::REG_ZERO; // RULE14

  // ----------------------------------------
  // Soft reinit command
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_q <= 1'b0;
    end else if (cmd_q) begin
      cmd_q <= 1'b0; // RULE2
    end else begin
      cmd_q <= wr_cmd && host_wr.wdata[pti_pkg::BIT_CMD]; // RULE1
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      defaults_restore <= 1'b0;
      otp_reload       <= 1'b0;
    end else begin
      defaults_restore <= cmd_q; // RULE1
      otp_reload       <= cmd_q; // RULE1
    end
  end

  // ----------------------------------------
  // Latched flags
  // ----------------------------------------
  logic [7:0] lat_q, set_v;
  logic       rstoc_q, tsd_clr;
  always_comb begin
    set_v = pti_pkg::REG_ZERO;
    set_v[pti_pkg::BIT_ILOAD] = evt_s_q.ilad_done && !evt_p_q.ilad_done; // RULE3
    set_v[pti_pkg::BIT_SYNC]  = evt_s_q.sync_valid != evt_p_q.sync_valid; // RULE7
    set_v[pti_pkg::BIT_TSD]   = evt_s_q.tsd && !evt_p_q.tsd; // RULE8
    set_v[pti_pkg::BIT_TWARN] = evt_s_q.twarn && !evt_p_q.twarn; // RULE11
    set_v[pti_pkg::BIT_OVERVOLT] = evt_s_q.overvolt && !evt_p_q.overvolt; // RULE12
  end
  assign tsd_clr = clr_top[pti_pkg::BIT_TSD] && lat_q[pti_pkg::BIT_TSD];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lat_q <= pti_pkg::REG_ZERO;
    end else if (cmd_q) begin
      lat_q <= pti_pkg::REG_ZERO; // RULE1
    end else begin
      lat_q <= (lat_q & ~clr_top) | set_v; // RULE3 RULE7 RULE11 RULE12 RULE14
      if (tsd_clr && !set_v[pti_pkg::BIT_TWARN]) begin
        lat_q[pti_pkg::BIT_TWARN] <= 1'b0; // RULE10
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rstoc_q <= 1'b1; // RULE13
    end else if (cmd_q || evt_s_q.uvlo) begin
      rstoc_q <= 1'b1; // RULE13
    end else if (wr_top2 && host_wr.wdata[pti_pkg::BIT_RSTOC]) begin
      rstoc_q <= 1'b0; // RULE13
    end
  end

  // ----------------------------------------
  // Converter enable gating
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_en <= '0;
    end else if (lat_q[pti_pkg::BIT_TSD] || set_v[pti_pkg::BIT_TSD] || cmd_q
                 || evt_s_q.uvlo) begin
      conv_en <= '0; // RULE8 RULE9 RULE13
    end else begin
      conv_en <= en_s_q; // RULE10
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] top_v, stat_v;
  always_comb begin
    top_v = lat_q;
    top_v[pti_pkg::BIT_MON]   = |monitor_event_reg; // RULE4
    top_v[pti_pkg::BIT_BOOST] = |boost_event_reg; // RULE5
    top_v[pti_pkg::BIT_BUCK]  = |buck_event_reg; // RULE6
    stat_v = pti_pkg::REG_ZERO;
    stat_v[pti_pkg::BIT_TSD]   = evt_s_q.tsd;
    stat_v[pti_pkg::BIT_TWARN] = evt_s_q.twarn; // RULE11
    stat_v[pti_pkg::BIT_OVERVOLT] = evt_s_q.overvolt; // RULE12
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= pti_pkg::REG_ZERO;
    end else begin
      case (rd_addr)
        pti_pkg::REG_SOFT_RESET: rd_data <= {7'h00, cmd_q};
        pti_pkg::REG_TOP_FLAGS:  rd_data <= top_v;
        pti_pkg::REG_TOP_FLAGS2: rd_data <= {7'h00, rstoc_q};
        pti_pkg::REG_TOP_STATUS: rd_data <= stat_v;
        default:                 rd_data <= pti_pkg::REG_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_CMD_SELF_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    cmd_q |=> !cmd_q)
    else $error("command bit did not self clear");
  AST_CMD_RESTORE: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    cmd_q |=> defaults_restore && otp_reload && lat_q == pti_pkg::REG_ZERO)
    else $error("reinit missing");
  AST_RSTOC_SET: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    cmd_q |=> rstoc_q)
    else $error("reset flag not set");
  AST_RSTOC_UVLO: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    evt_s_q.uvlo |=> rstoc_q && conv_en == '0)
    else $error("undervoltage did not reset");

  AST_TSD_LATCH: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    (evt_s_q.tsd && !evt_p_q.tsd && !cmd_q) |=> lat_q[pti_pkg::BIT_TSD])
    else $error("shutdown not latched");
  AST_TSD_BLOCKS: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
    lat_q[pti_pkg::BIT_TSD] |=> conv_en == '0)
    else $error("converter enabled in shutdown");
  AST_TSD_CLR_WARN: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    (tsd_clr && !cmd_q && !set_v[pti_pkg::BIT_TWARN] && !set_v[pti_pkg::BIT_TSD]) |=>
    !lat_q[pti_pkg::BIT_TWARN] && !lat_q[pti_pkg::BIT_TSD])
    else $error("warning kept after shutdown clear");
  AST_EN_FOLLOWS: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    (!lat_q[pti_pkg::BIT_TSD] && !set_v[pti_pkg::BIT_TSD] && !cmd_q && !evt_s_q.uvlo) |=>
    conv_en == $past(en_s_q))
    else $error("converter enable did not follow request");

  AST_SYNC_EDGE: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    ($changed(evt_s_q.sync_valid) && !cmd_q) |-> ##1 lat_q[pti_pkg::BIT_SYNC])
    else $error("sync change lost");
  AST_ILOAD_LATCH: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (evt_s_q.ilad_done && !evt_p_q.ilad_done && !cmd_q) |=> lat_q[pti_pkg::BIT_ILOAD])
    else $error("load flag not latched");
  AST_ILOAD_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (lat_q[pti_pkg::BIT_ILOAD] && !clr_top[pti_pkg::BIT_ILOAD] && !cmd_q) |=> lat_q[pti_pkg::BIT_ILOAD])
    else $error("load flag dropped");
  AST_WARN_LATCH: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    (evt_s_q.twarn && !evt_p_q.twarn && !cmd_q) |=> lat_q[pti_pkg::BIT_TWARN])
    else $error("warning not latched");
  AST_OVERVOLT_LATCH: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
    (evt_s_q.overvolt && !evt_p_q.overvolt && !cmd_q) |=> lat_q[pti_pkg::BIT_OVERVOLT])
    else $error("overvoltage not latched");
  AST_ZERO_KEEPS: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    (wr_top && host_wr.wdata == pti_pkg::REG_ZERO && !cmd_q) |=>
    (lat_q & $past(lat_q)) == $past(lat_q))
    else $error("zero write cleared flag");

  AST_MON_SUMMARY: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    (rd_addr == pti_pkg::REG_TOP_FLAGS) |=>
    rd_data[pti_pkg::BIT_MON] == ($past(monitor_event_reg) != pti_pkg::REG_ZERO))
    else $error("monitor summary mismatch");
  AST_BOOST_SUMMARY: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    (rd_addr == pti_pkg::REG_TOP_FLAGS) |=>
    rd_data[pti_pkg::BIT_BOOST] == ($past(boost_event_reg) != pti_pkg::REG_ZERO))
    else $error("boost summary mismatch");
  AST_BUCK_SUMMARY: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    (rd_addr == pti_pkg::REG_TOP_FLAGS) |=>
    rd_data[pti_pkg::BIT_BUCK] == ($past(buck_event_reg) != pti_pkg::REG_ZERO))
    else $error("step-down summary mismatch");

  // ----------------------------------------
  // Cover properties
  // ----------------------------------------
  COV_TSD: cover property (@(posedge ref_clk) disable iff (rst)
    lat_q[pti_pkg::BIT_TSD] ##[1:20] !lat_q[pti_pkg::BIT_TSD]);
  COV_CMD: cover property (@(posedge ref_clk) disable iff (rst) cmd_q);
  COV_SYNC: cover property (@(posedge ref_clk) disable iff (rst) set_v[pti_pkg::BIT_SYNC]);
  COV_UVLO: cover property (@(posedge ref_clk) disable iff (rst) evt_s_q.uvlo);
  COV_WARN_BY_TSD: cover property (@(posedge ref_clk) disable iff (rst)
    tsd_clr && lat_q[pti_pkg::BIT_TWARN]);
endmodule : pti_top

//--- verification/pti_host_model.sv
`timescale 1ns/1ps
module pti_host_model (
  input  wire logic        ref_clk,
  output pti_pkg::pti_wr_t host_wr,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data
);
  // ----------------------------------------
  // Host register access at falling edges
  // ----------------------------------------
  initial begin
    host_wr = '0;
    rd_addr = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_wr = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge ref_clk);
    host_wr = '{wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    rd_addr = a;
    @(negedge ref_clk);
    d = rd_data;
  endtask : rd
endmodule : pti_host_model

//--- verification/pti_top_tb_top.sv
`timescale 1ns/1ps
module pti_top_tb_top;
  logic              ref_clk;
  logic              rst;
  pti_pkg::pti_wr_t  host_wr;
  pti_pkg::pti_evt_t evt;
  logic [7:0]        rd_addr, rd_data, buck, boost, mon, d;
  logic [2:0]        req, conv_en;
  logic              defaults_restore, otp_reload;
  int                bad_count = 0;
  int                checks = 0;
  pti_top i_pti_top (.ref_clk(ref_clk), .rst(rst), .host_wr(host_wr), .rd_addr(rd_addr),
    .evt_in(evt), .buck_event_reg(buck), .boost_event_reg(boost), .monitor_event_reg(mon),
    .conv_en_req(req), .rd_data(rd_data), .conv_en(conv_en),
    .defaults_restore(defaults_restore), .otp_reload(otp_reload));
  pti_host_model i_pti_host_model (.ref_clk(ref_clk), .host_wr(host_wr), .rd_addr(rd_addr),
    .rd_data(rd_data));
  // ----------------------------------------
  // Shared checks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_pti_host_model.rd(a, d);
    chk("read data", e, d);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_pti_host_model.wr(a, v);
  endtask : wr
  task automatic settle;
    repeat (4) @(negedge ref_clk);
  endtask : settle
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_flag;
    rchk(8'h1F, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'h01);
    wr(8'h21, 8'h01);
    rchk(8'h21, 8'h00);
  endtask : test_reset_flag
  task automatic test_latch;
    evt = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0}; // Load, sync, warning, overvoltage high
    settle;
    rchk(8'h20, 8'h8B);
    rchk(8'h2F, 8'h03);
    wr(8'h20, 8'h00);
    wr(8'h20, 8'h70);
    rchk(8'h20, 8'h8B);
    evt = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}; // Only sync stays high
    wr(8'h20, 8'h8B);
    rchk(8'h20, 8'h00);
    evt.sync_valid = 1'b0;
    settle;
    rchk(8'h20, 8'h08);
    wr(8'h20, 8'h08);
    rchk(8'h20, 8'h00);
  endtask : test_latch
  task automatic test_summary;
    buck = 8'h01;
    rchk(8'h20, 8'h10);
    buck = 8'h00;
    boost = 8'h04;
    rchk(8'h20, 8'h20);
    boost = 8'h00;
    mon = 8'h80;
    rchk(8'h20, 8'h40);
    wr(8'h20, 8'h40);
    rchk(8'h20, 8'h40);
    mon = 8'h00;
    rchk(8'h20, 8'h00);
  endtask : test_summary
  task automatic test_thermal;
    req = 3'h7;
    settle;
    chk("conv_en", 8'h07, {5'h00, conv_en});
    evt = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}; // Shutdown and warning high
    settle;
    chk("conv_en", 8'h00, {5'h00, conv_en});
    rchk(8'h20, 8'h06);
    rchk(8'h2F, 8'h06);
    evt = '0;
    settle;
    chk("conv_en", 8'h00, {5'h00, conv_en});
    wr(8'h20, 8'h04);
    rchk(8'h20, 8'h00);
    settle;
    chk("conv_en", 8'h07, {5'h00, conv_en});
  endtask : test_thermal
  task automatic test_soft_reset;
    evt.overvolt = 1'b1;
    settle;
    rchk(8'h1F, 8'h00);
    wr(8'h1F, 8'h01);
    @(negedge ref_clk);
    chk("pulses", 8'h03, {6'h00, defaults_restore, otp_reload});
    chk("command bit", 8'h01, rd_data);
    @(negedge ref_clk);
    chk("pulses", 8'h00, {6'h00, defaults_restore, otp_reload});
    chk("command bit", 8'h00, rd_data);
    evt.overvolt = 1'b0;
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'h01);
    wr(8'h21, 8'h01);
    rchk(8'h21, 8'h00);
    evt.uvlo = 1'b1;
    settle;
    chk("conv_en", 8'h00, {5'h00, conv_en});
    rchk(8'h21, 8'h01);
    evt.uvlo = 1'b0;
  endtask : test_soft_reset
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    evt = '0;
    req = 3'h0;
    buck = 8'h00;
    boost = 8'h00;
    mon = 8'h00;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    test_reset_flag();
    test_latch();
    test_summary();
    test_thermal();
    test_soft_reset();
    complete_run();
  end
endmodule : pti_top_tb_top
